// ---- jkss_consts.vh ----
`ifndef JKSS_CONSTS_VH
`define JKSS_CONSTS_VH

// ************************************************************
// clocking schemes, one-hot
// ************************************************************
`define JKSS_MODE_RISE  4'h1
`define JKSS_MODE_FALL  4'h2
`define JKSS_MODE_MSLO  4'h4
`define JKSS_MODE_MSHI  4'h8

// ************************************************************
// input gating structures
// ************************************************************
`define JKSS_GATE_NONE  2'h0
`define JKSS_GATE_EN    2'h1
`define JKSS_GATE_AND   2'h2
`define JKSS_GATE_ANDOR 2'h3

// ************************************************************
// reset values and slot layout
// ************************************************************
`define JKSS_Q_RST      1'b0
`define JKSS_REQ_RST    1'b1
`define JKSS_HOLD_RST   1'b0
`define JKSS_SYNC_RST   9'h18f
`define JKSS_NSLOT      3
`define JKSS_SLOT_ELEM  0
`define JKSS_SLOT_REQ   1
`define JKSS_SLOT_HOLD  2
`define JKSS_WARM_W     3

`endif

// ---- jkss_sync.v ----
`timescale 1ns/100ps
`include "jkss_consts.vh"

module jkss_sync
#(
   parameter         W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
   // clock and reset
   input  wire         mclk_i,
   input  wire         rstn_i,
   // asynchronous pins and their synchronised copy
   input  wire [W-1:0] pin_i,
   output wire [W-1:0] pin_s_o
);

   reg [W-1:0] meta;
   reg [W-1:0] stable;

   // ************************************************************
   // two-stage synchroniser
   // ************************************************************
   // meta is read only by stable; reset to the idle pin levels
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta   <= RST_VAL;
         stable <= RST_VAL;
      end
      else
      begin
         meta   <= pin_i;
         stable <= meta;
      end
   end

   assign pin_s_o = stable;

endmodule // jkss_sync

// ---- jkss_gate.v ----
`timescale 1ns/100ps
`include "jkss_consts.vh"

module jkss_gate
#(
   parameter [1:0] GATE = `JKSS_GATE_NONE,
   parameter       GW   = 2
)
(
   // data sources
   input  wire [GW-1:0] set_i,
   input  wire [GW-1:0] reset_i,
   input  wire          reset_n_i,
   input  wire          set_alt_i,
   input  wire          reset_alt_i,
   // gating controls, enable active low
   input  wire          en_n_i,
   input  wire          sel_i,
   // gated set and reset conditions
   output reg           set_o,
   output reg           reset_o
);

   // ************************************************************
   // gating of set and reset
   // ************************************************************
   // reset_n_i is the inverted reset input in all but JKSS_GATE_ANDOR; tie it to set for a d input
   always @*
   begin
      case (GATE)
         `JKSS_GATE_EN:
         begin
            set_o   = set_i[0] & ~en_n_i;
            reset_o = (reset_i[0] | ~reset_n_i) & ~en_n_i;
         end
         `JKSS_GATE_AND:
         begin
            set_o   = &set_i;
            reset_o = (&reset_i) | ~reset_n_i;
         end
         `JKSS_GATE_ANDOR:
         begin
            set_o   = sel_i ? set_alt_i : &set_i;
            reset_o = sel_i ? reset_alt_i : &reset_i;
         end
         default:
         begin
            set_o   = set_i[0];
            reset_o = reset_i[0] | ~reset_n_i;
         end
      endcase
   end

endmodule // jkss_gate

// ---- jkss_top.v ----
`timescale 1ns/100ps
`include "jkss_consts.vh"

module jkss_top
#(
   parameter [3:0] MODE      = `JKSS_MODE_RISE,
   parameter [1:0] GATE      = `JKSS_GATE_NONE,
   parameter       GW        = 2,
   parameter       HAS_PRE   = 1,
   parameter       HAS_CLR   = 1,
   parameter       PRE_GATED = 0
)
(
   // clock and reset
   input  wire          mclk_i,
   input  wire          rstn_i,
   // configurable element: its clock and data inputs
   input  wire          elem_clk_i,
   input  wire [GW-1:0] elem_set_i,
   input  wire [GW-1:0] elem_reset_i,
   input  wire          elem_reset_n_i,
   input  wire          elem_set_alt_i,
   input  wire          elem_reset_alt_i,
   // configurable element: gating and forcing inputs
   input  wire          elem_en_n_i,
   input  wire          elem_sel_i,
   input  wire          elem_pre_n_i,
   input  wire          elem_clr_n_i,
   // configurable element: stored state
   output wire          elem_q_o,
   output wire          elem_qn_o,
   // switch synchronizer: contacts and completion
   input  wire          sw_press_n_i,
   input  wire          sw_rest_n_i,
   input  wire          routine_done_i,
   // switch synchronizer: state
   output wire          request_o,
   output wire          hold_o
);

   localparam NS = `JKSS_NSLOT;
   localparam SW = 2 * GW + 10;
   localparam [SW-1:0] SYNC_RST = {{(2*GW+1){1'b0}}, `JKSS_SYNC_RST};

   // ************************************************************
   // pin synchronisation
   // ************************************************************
   wire [SW-1:0] pin_raw;
   wire [SW-1:0] pin_s;
   wire          ck;
   wire [GW-1:0] set_s;
   wire [GW-1:0] reset_s;
   wire          reset_n_s;
   wire          en_n_s;
   wire          sel_s;
   wire          set_alt_s;
   wire          reset_alt_s;
   wire          pre_n_s;
   wire          clr_n_s;
   wire          press_n_s;
   wire          rest_n_s;

   // every pin but routine_done_i is asynchronous to mclk_i, so those all share one pipe
   assign pin_raw = {elem_clk_i, elem_set_i, elem_reset_i,
                     elem_reset_n_i, elem_en_n_i, elem_sel_i,
                     elem_set_alt_i, elem_reset_alt_i,
                     elem_pre_n_i, elem_clr_n_i,
                     sw_press_n_i, sw_rest_n_i};

   jkss_sync
   #(
      .W       (SW),
      .RST_VAL (SYNC_RST)
   )
   u_sync
   (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .pin_i   (pin_raw),
      .pin_s_o (pin_s)
   );

   // unpack in the same order as packed
   assign {ck, set_s, reset_s, reset_n_s, en_n_s, sel_s,
           set_alt_s, reset_alt_s, pre_n_s, clr_n_s,
           press_n_s, rest_n_s} = pin_s;

   // ************************************************************
   // input gating of the configurable element
   // ************************************************************
   wire gset;
   wire greset;

   jkss_gate
   #(
      .GATE (GATE),
      .GW   (GW)
   )
   u_gate
   (
      .set_i       (set_s),
      .reset_i     (reset_s),
      .reset_n_i   (reset_n_s),
      .set_alt_i   (set_alt_s),
      .reset_alt_i (reset_alt_s),
      .en_n_i      (en_n_s),
      .sel_i       (sel_s),
      .set_o       (gset),
      .reset_o     (greset)
   );

   // ************************************************************
   // element clock edges and warm-up
   // ************************************************************
   reg                    ck_d;
   reg                    gset_d;
   reg                    greset_d;
   reg [`JKSS_WARM_W-1:0] warm;
   wire                   armed;
   wire                   ck_rise;
   wire                   ck_fall;

   // inputs are delayed with the clock so an edge sees the
   // conditions that stood just before it
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ck_d     <= 1'b0;
         gset_d   <= 1'b0;
         greset_d <= 1'b0;
         warm     <= {`JKSS_WARM_W{1'b0}};
      end
      else
      begin
         ck_d     <= ck;
         gset_d   <= gset;
         greset_d <= greset;
         warm     <= {warm[`JKSS_WARM_W-2:0], 1'b1};
      end
   end

   // no edge counts until the pipe holds real pin levels, which
   // avoids a phantom edge when the clock pin idles high
   assign armed   = warm[`JKSS_WARM_W-1];
   assign ck_rise = armed & ck & ~ck_d;
   assign ck_fall = armed & ~ck & ck_d;

   // ************************************************************
   // switch contact latch
   // ************************************************************
   reg pressed;

   // both throws of the switch form a set/reset latch, so contact
   // bounce on one throw never toggles the level
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pressed <= 1'b0;
      else if (!press_n_s)
         pressed <= 1'b1;
      else if (!rest_n_s)
         pressed <= 1'b0;
      else
         pressed <= pressed;
   end

   // ************************************************************
   // per-slot stimulus
   // ************************************************************
   wire [NS-1:0] s_rise;
   wire [NS-1:0] s_fall;
   wire [NS-1:0] s_lo;
   wire [NS-1:0] s_hi;
   wire [NS-1:0] s_set;
   wire [NS-1:0] s_reset;
   wire [NS-1:0] s_pre;
   wire [NS-1:0] s_clr;
   wire [NS-1:0] slot_q;
   wire          req;
   wire          hold;
   wire          force_ok;

   assign req  = slot_q[`JKSS_SLOT_REQ];
   assign hold = slot_q[`JKSS_SLOT_HOLD];

   // the gated variant only lets the forcing inputs act while the
   // element clock is low
   assign force_ok = (PRE_GATED != 0) ? ~ck : 1'b1;

   // switch slots step on every mclk edge; slot order hold,req,elem
   assign s_rise  = {1'b1, 1'b1, ck_rise};
   assign s_fall  = {1'b0, 1'b0, ck_fall};
   assign s_lo    = {1'b0, 1'b0, armed & ~ck};
   assign s_hi    = {1'b0, 1'b0, armed & ck};
   assign s_pre   = {1'b0, 1'b0,
                     (HAS_PRE != 0) & ~pre_n_s & force_ok};
   assign s_clr   = {1'b0, 1'b0,
                     (HAS_CLR != 0) & ~clr_n_s & force_ok};

   // request: set on completion, reset on press unless held
   // hold: set once request dropped, reset once switch released with request high
   assign s_set   = {~req,
                     routine_done_i,
                     gset_d};
   assign s_reset = {req & ~pressed,
                     pressed & ~hold,
                     greset_d};

   // ************************************************************
   // storage elements
   // ************************************************************
   function next_q;
      input q;
      input s;
      input r;
      begin
         case ({s, r})
            2'h3:    next_q = ~q;
            2'h2:    next_q = 1'b1;
            2'h1:    next_q = 1'b0;
            default: next_q = q;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NS; g = g + 1)
      begin : g_slot
         localparam [3:0] SMODE = (g == `JKSS_SLOT_ELEM) ? MODE
                                                        : `JKSS_MODE_RISE;
         localparam [0:0] RSTV  = (g == `JKSS_SLOT_REQ)  ? `JKSS_REQ_RST :
                                  (g == `JKSS_SLOT_HOLD) ? `JKSS_HOLD_RST :
                                                           `JKSS_Q_RST;
         reg  master;
         reg  slave;
         wire take_set;
         wire take_reset;

         // master moves only toward the opposite of the slave, so
         // once it differs nothing returns it before the next pulse
         assign take_set   = s_set[g] & ~slave;
         assign take_reset = s_reset[g] & slave;

         // clear wins over preset; both stages are forced together
         always @(posedge mclk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               master <= RSTV;
               slave  <= RSTV;
            end
            else if (s_clr[g])
            begin
               master <= 1'b0;
               slave  <= 1'b0;
            end
            else if (s_pre[g])
            begin
               master <= 1'b1;
               slave  <= 1'b1;
            end
            else
            begin
               case (SMODE)
                  `JKSS_MODE_RISE:
                  begin
                     // inputs away from the edge are never looked at
                     if (s_rise[g])
                     begin
                        slave  <= next_q(slave, s_set[g], s_reset[g]);
                        master <= next_q(slave, s_set[g], s_reset[g]);
                     end
                  end
                  `JKSS_MODE_FALL:
                  begin
                     if (s_fall[g])
                     begin
                        slave  <= next_q(slave, s_set[g], s_reset[g]);
                        master <= next_q(slave, s_set[g], s_reset[g]);
                     end
                  end
                  `JKSS_MODE_MSLO:
                  begin
                     if (s_rise[g])
                        slave <= master;
                     else if (s_lo[g] & take_set)
                        master <= 1'b1;
                     else if (s_lo[g] & take_reset)
                        master <= 1'b0;
                  end
                  `JKSS_MODE_MSHI:
                  begin
                     if (s_fall[g])
                        slave <= master;
                     else if (s_hi[g] & take_set)
                        master <= 1'b1;
                     else if (s_hi[g] & take_reset)
                        master <= 1'b0;
                  end
                  default:
                  begin
                     master <= master;
                     slave  <= slave;
                  end
               endcase
            end
         end

         assign slot_q[g] = slave;
      end
   endgenerate

   // ************************************************************
   // outputs
   // ************************************************************
   // request stays high from completion until the next press, so the
   // surrounding logic can treat it as a synchronous control level
   assign elem_q_o  = slot_q[`JKSS_SLOT_ELEM];
   assign elem_qn_o = ~slot_q[`JKSS_SLOT_ELEM];
   assign request_o = req;
   assign hold_o    = hold;

endmodule // jkss_top

// ---- jkss_top_chk.sv ----
`timescale 1ns/100ps

module jkss_top_chk
#(
   parameter GW = 2
)
(
   // clock and reset
   input wire          mclk_i,
   input wire          rstn_i,
   // element
   input wire          elem_clk_i,
   input wire [GW-1:0] elem_set_i,
   input wire [GW-1:0] elem_reset_i,
   input wire          elem_pre_n_i,
   input wire          elem_clr_n_i,
   input wire          elem_q_o,
   input wire          elem_qn_o,
   // switch synchronizer
   input wire          sw_press_n_i,
   input wire          sw_rest_n_i,
   input wire          routine_done_i,
   input wire          request_o,
   input wire          hold_o
);
   // ******
   // helper
   // ******
   reg [2:0] quiet;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   // cycles since the last clock rise or forcing, saturating at 7
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         quiet <= 3'h0;
      else if ($rose(elem_clk_i) || !elem_pre_n_i || !elem_clr_n_i)
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   end

   // **********
   // assertions
   // **********
   // element timings hold for the rising scheme only
   AST_IDLE_RST: assert property (
      $rose(rstn_i) |-> request_o && !hold_o && !elem_q_o)
      else $error("state after reset wrong");
   AST_INV_OUT: assert property (elem_qn_o == !elem_q_o)
      else $error("inverted output wrong");
   AST_SET_RESET: assert property (
      $rose(elem_clk_i) && elem_set_i[0] != elem_reset_i[0]
      && elem_pre_n_i && elem_clr_n_i
      |-> ##4 elem_q_o == $past(elem_set_i[0], 4))
      else $error("set or reset not taken");
   AST_TOGGLE_HOLD: assert property (
      $rose(elem_clk_i) && elem_set_i[0] == elem_reset_i[0]
      && elem_pre_n_i && elem_clr_n_i
      |-> ##4 elem_q_o == ($past(elem_q_o, 4) ^ $past(elem_set_i[0], 4)))
      else $error("toggle or hold wrong");
   AST_EDGE_ONLY: assert property (quiet > 3'h4 |-> $stable(elem_q_o))
      else $error("state moved away from an edge");
   AST_PRESET: assert property (
      (!elem_pre_n_i && elem_clr_n_i) [*4] |=> elem_q_o)
      else $error("preset not forcing high");
   AST_CLEAR: assert property ((!elem_clr_n_i) [*4] |=> !elem_q_o)
      else $error("clear not forcing low");
   AST_PRESS: assert property (
      request_o && !hold_o && $fell(sw_press_n_i) |-> ##[1:6] !request_o)
      else $error("press not taken");
   AST_HOLD_NEXT: assert property (
      $fell(request_o) |=> hold_o && !request_o)
      else $error("hold not set after request");
   AST_LOCKED: assert property (
      !request_o && hold_o && !routine_done_i |=> !request_o && hold_o)
      else $error("locked state left");
   AST_DONE: assert property (
      routine_done_i && !request_o |=> request_o)
      else $error("done did not set request");
   AST_RELEASE: assert property (
      request_o && hold_o && !sw_rest_n_i |-> ##[1:5] !hold_o)
      else $error("hold not cleared on release");
endmodule // jkss_top_chk

// ---- jkss_sw_model.sv ----
`timescale 1ns/100ps

module jkss_sw_model
(
   // clock
   input  wire       mclk_i,
   // bench commands
   input  wire       press_i,
   input  wire [3:0] lag_i,
   // request seen from the synchronizer
   input  wire       request_i,
   // switch throws and completion
   output reg        sw_press_n_o,
   output reg        sw_rest_n_o,
   output reg        routine_done_o
);
   reg       press_q;
   reg       req_q;
   reg       fired;
   reg [3:0] bnc;
   reg [3:0] wait_cnt;

   // switch at rest, no routine running
   initial
   begin
      sw_press_n_o = 1'b1;
      sw_rest_n_o = 1'b0;
      routine_done_o = 1'b0;
      press_q = 1'b0;
      fired = 1'b0;
      bnc = 4'hf;
      wait_cnt = 4'h0;
   end

   // inputs taken at the edge, outputs moved just after it
   always @(posedge mclk_i)
   begin
      bnc = (press_i != press_q) ? 4'h0 : bnc + {3'h0, bnc != 4'hf};
      press_q = press_i;
      req_q = request_i;
      #1;
      // the moving throw bounces three times; both are never low at once
      if (press_q)
      begin
         sw_rest_n_o = 1'b1;
         sw_press_n_o = (bnc < 4'h3) ? ~sw_press_n_o : 1'b0;
      end
      else
      begin
         sw_press_n_o = 1'b1;
         sw_rest_n_o = (bnc < 4'h3) ? ~sw_rest_n_o : 1'b0;
      end
      // routine starts when request falls, ends with a one-cycle done
      routine_done_o = 1'b0;
      if (req_q)
      begin
         fired = 1'b0;
         wait_cnt = 4'h0;
      end
      else if (!fired)
      begin
         if (wait_cnt == lag_i)
         begin
            routine_done_o = 1'b1;
            fired = 1'b1;
         end
         wait_cnt = wait_cnt + 4'h1;
      end
   end
endmodule // jkss_sw_model

// ---- tb.sv ----
`timescale 1ns/100ps

`define CHK(a, e, m) \
   begin \
      n_compared = n_compared + 1; \
      if ((a) !== (e)) \
      begin \
         bad_count = bad_count + 1; \
         $display("FAIL %0t %s", $time, m); \
      end \
   end

module tb;
   typedef struct {int due; int which; logic v;} jkss_note_t;

   reg         mclk_i;
   reg         rstn_i;
   reg         elem_clk_i;
   reg  [1:0]  elem_set_i;
   reg  [1:0]  elem_reset_i;
   reg         elem_pre_n_i;
   reg         elem_clr_n_i;
   reg         press;
   reg  [3:0]  lag;
   reg  [31:0] rnd;
   reg         q_m;
   wire        elem_q_o;
   wire        elem_qn_o;
   wire        sw_press_n_i;
   wire        sw_rest_n_i;
   wire        routine_done_i;
   wire        request_o;
   wire        hold_o;
   integer     seed;
   integer     bad_count = 0;
   integer     n_compared = 0;
   integer     cyc = 0;
   integer     i;
   jkss_note_t notes[$];
   jkss_note_t nt;

   // ***************
   // design and far side
   // ***************
   jkss_top uut (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .elem_clk_i(elem_clk_i),
      .elem_set_i(elem_set_i), .elem_reset_i(elem_reset_i),
      .elem_reset_n_i(1'b1), .elem_set_alt_i(1'b0),
      .elem_reset_alt_i(1'b0), .elem_en_n_i(1'b0), .elem_sel_i(1'b0),
      .elem_pre_n_i(elem_pre_n_i), .elem_clr_n_i(elem_clr_n_i),
      .elem_q_o(elem_q_o), .elem_qn_o(elem_qn_o),
      .sw_press_n_i(sw_press_n_i), .sw_rest_n_i(sw_rest_n_i),
      .routine_done_i(routine_done_i), .request_o(request_o),
      .hold_o(hold_o));

   jkss_sw_model u_sw (
      .mclk_i(mclk_i), .press_i(press), .lag_i(lag),
      .request_i(request_o), .sw_press_n_o(sw_press_n_i),
      .sw_rest_n_o(sw_rest_n_i), .routine_done_o(routine_done_i));

   // clock and cycle count
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i)
      cyc <= cyc + 1;

   // *******
   // helpers
   // *******
   task tick(input integer n);
      begin
         repeat (n) @(posedge mclk_i);
         #1;
      end
   endtask

   // note an expected value, due in the current cycle
   task expect_at(input integer which, input logic v);
      begin
         nt.due = cyc;
         nt.which = which;
         nt.v = v;
         notes.push_back(nt);
      end
   endtask

   // one element clock pulse; junk on bit 1 throughout, on bit 0 only while the clock is low
   task clk_cycle(input logic s, input logic r);
      begin
         rnd = $random(seed);
         elem_set_i = {rnd[1], s};
         elem_reset_i = {rnd[2], r};
         tick(2);
         elem_clk_i = 1'b1;
         q_m = (s && r) ? ~q_m : ((s || r) ? s : q_m);
         tick(2);
         elem_clk_i = 1'b0;
         tick(2);
         expect_at(0, q_m);
         rnd = $random(seed);
         elem_set_i = rnd[1:0];
         elem_reset_i = rnd[3:2];
         tick(3);
      end
   endtask

   task force_pins(input logic p, input logic c, input logic v);
      begin
         elem_pre_n_i = p;
         elem_clr_n_i = c;
         tick(4);
         expect_at(0, v);
         elem_pre_n_i = 1'b1;
         elem_clr_n_i = 1'b1;
         q_m = v;
         tick(4);
      end
   endtask

   task stop_test;
      begin
         if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // oldest note compared once its cycle has come
   always @(negedge mclk_i)
      while (notes.size() != 0 && notes[0].due <= cyc)
      begin
         nt = notes.pop_front();
         case (nt.which)
            0:
            begin
               `CHK(elem_q_o, nt.v, "element state")
               `CHK(elem_qn_o, ~nt.v, "inverted state")
            end
            1: `CHK(request_o, nt.v, "request")
            default: `CHK(hold_o, nt.v, "hold")
         endcase
      end

   // hang guard, far beyond the few hundred cycles needed
   initial
   begin
      #(40 * 2000);
      bad_count = bad_count + 1;
      $display("FAIL %0t %s", $time, "timeout");
      stop_test;
   end

   // *********
   // sequence
   // *********
   initial
   begin
      seed = 20;
      q_m = 1'b0;
      rstn_i = 1'b0;
      elem_clk_i = 1'b0;
      elem_set_i = 2'h0;
      elem_reset_i = 2'h0;
      elem_pre_n_i = 1'b1;
      elem_clr_n_i = 1'b1;
      press = 1'b0;
      lag = 4'h0;
      tick(8);
      rstn_i = 1'b1;
      expect_at(0, 1'b0);
      expect_at(1, 1'b1);
      expect_at(2, 1'b0);
      tick(5);
      // every set/reset combination first, then random ones
      for (i = 0; i < 24; i = i + 1)
      begin
         rnd = $random(seed);
         if (i < 8)
            rnd[1:0] = i[1:0];
         clk_cycle(rnd[0], rnd[1]);
      end
      force_pins(1'b0, 1'b1, 1'b1);
      force_pins(1'b1, 1'b0, 1'b0);
      force_pins(1'b0, 1'b0, 1'b0);
      // switch held past the end of a quick routine
      press = 1'b1;
      tick(20);
      expect_at(1, 1'b1);
      expect_at(2, 1'b1);
      press = 1'b0;
      tick(8);
      expect_at(1, 1'b1);
      expect_at(2, 1'b0);
      // switch released while a slow routine still runs
      lag = 4'hc;
      press = 1'b1;
      tick(9);
      expect_at(1, 1'b0);
      expect_at(2, 1'b1);
      press = 1'b0;
      tick(8);
      expect_at(1, 1'b0);
      expect_at(2, 1'b1);
      tick(15);
      expect_at(1, 1'b1);
      expect_at(2, 1'b0);
      tick(2);
      stop_test;
   end
endmodule // tb

bind jkss_top jkss_top_chk #(.GW(GW)) u_chk (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .elem_clk_i(elem_clk_i),
   .elem_set_i(elem_set_i), .elem_reset_i(elem_reset_i),
   .elem_pre_n_i(elem_pre_n_i), .elem_clr_n_i(elem_clr_n_i),
   .elem_q_o(elem_q_o), .elem_qn_o(elem_qn_o),
   .sw_press_n_i(sw_press_n_i), .sw_rest_n_i(sw_rest_n_i),
   .routine_done_i(routine_done_i), .request_o(request_o),
   .hold_o(hold_o));
